// ==== src/host_serial_register_port.v ====
// Notes on behaviour
// R01: status shows write pending, read pending, busy
// R02: read address word latched, starts read
// R03: write address word latched as pointer
// R04: data word 12 bits, pointers auto increment
// R05: one 16-bit word per serial transaction
// R06: fixed maker code at subaddress zero
// R07: part number low at 1, high at 2
// R08: field indicator in bit 0, rest ignored
// R09: bits 2..0 set port A data drive
// R10: bits 5..3 set clock and valid drive
// R11: pixel clock drive ORs shifted bits 7..6
// R12: host waits for busy clear before access
`timescale 1ns/1ns
`include "host_serial_register_port_regs.vh"
module host_serial_register_port #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
  parameter [7:0] MAKER_CODE = `MAKER_CODE_DEFAULT,
  parameter [15:0] PART_NUMBER = `PART_NUMBER_DEFAULT
) (
  input wire mclk_in,
  input wire rst_n_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_out,
  input wire field_in,
  output reg ram_rd_req_out,
  output reg [8:0] ram_rd_addr_out,
  input wire ram_rd_ack_in,
  input wire [11:0] ram_rd_data_in,
  output reg ram_wr_req_out,
  output reg [8:0] ram_wr_addr_out,
  output reg [11:0] ram_wr_data_out,
  input wire ram_wr_ack_in,
  output reg [2:0] port_a_data_drive_out,
  output reg [2:0] clock_valid_pad_drive_out,
  output reg [2:0] pixel_clock_drive_out
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_TACK = 5'h10;

  localparam [1:0] K_ADDR = 2'h0;
  localparam [1:0] K_SUB = 2'h1;
  localparam [1:0] K_DATA = 2'h2;

  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg scl_reg;
  reg sda_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  reg [4:0] state_reg;
  reg [1:0] kind_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [7:0] hold_reg;
  reg [7:0] sub_reg;
  reg [1:0] byte_idx_reg;
  reg rw_reg;
  reg tx_more_reg;
  reg ack_ok_reg;
  reg [11:0] data_buf_reg;
  reg [7:0] drive_reg;

  reg [15:0] rd_val;
  reg rd_wide;
  reg wr_ok;
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [15:0] rx_word;
  wire [7:0] tx_first;

  // open drain: only ever pulls low, the enable carries the data
  assign sda_out = 1'b0;

  assign scl_rise = scl_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_reg & scl_prev_reg;
  assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  assign bus_stop = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  assign rx_word = {hold_reg, shift_reg};
  assign tx_first = rd_wide ? rd_val[15:8] : rd_val[7:0];

  // read view and write permission per subaddress
  always @* begin
    rd_val = 16'h0000;
    rd_wide = 1'b0;
    wr_ok = 1'b0;
    case (sub_reg)
      `OFS_MAKER_CODE: rd_val = {8'h00, MAKER_CODE}; // R06
      `OFS_PART_NUMBER_LOW: rd_val = {8'h00, PART_NUMBER[7:0]}; // R07
      `OFS_PART_NUMBER_HIGH: rd_val = {8'h00, PART_NUMBER[15:8]}; // R07
      `OFS_FIELD_INDICATOR_STATUS: rd_val = {15'h0000, field_in}; // R08
      `OFS_INDIRECT_STATUS: begin
        rd_val[`STAT_WRITE_PENDING_BIT] = ram_wr_req_out; // R01
        rd_val[`STAT_READ_PENDING_BIT] = ram_rd_req_out; // R01
        rd_val[`STAT_BUSY_BIT] = ram_wr_req_out | ram_rd_req_out; // R01
      end
      `OFS_INDIRECT_READ_ADDRESS, `OFS_INDIRECT_WRITE_ADDRESS: begin
        rd_wide = 1'b1;
        wr_ok = 1'b1;
      end
      `OFS_INDIRECT_DATA: begin
        rd_val = {4'h0, data_buf_reg}; // R04
        rd_wide = 1'b1;
        wr_ok = 1'b1;
      end
      `OFS_PORT_A_DRIVE_STRENGTH: begin
        rd_val = {8'h00, drive_reg};
        wr_ok = 1'b1;
      end
      default: rd_val = 16'h0000;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      state_reg <= S_IDLE;
      kind_reg <= K_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      hold_reg <= 8'h00;
      sub_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      rw_reg <= 1'b0;
      tx_more_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      data_buf_reg <= `RAM_DATA_RESET;
      drive_reg <= `DRIVE_STRENGTH_RESET;
      sda_oe_out <= 1'b0;
      ram_rd_req_out <= 1'b0;
      ram_rd_addr_out <= `RAM_ADDR_RESET;
      ram_wr_req_out <= 1'b0;
      ram_wr_addr_out <= `RAM_ADDR_RESET;
      ram_wr_data_out <= `RAM_DATA_RESET;
      port_a_data_drive_out <= 3'h0;
      clock_valid_pad_drive_out <= 3'h0;
      pixel_clock_drive_out <= 3'h0;
    end else begin
      // a level counts once the second and third stages agree
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;

      // completions first, so that a new request in the same cycle wins
      if (ram_rd_ack_in) begin
        data_buf_reg <= ram_rd_data_in;
        ram_rd_req_out <= 1'b0;
      end
      if (ram_wr_ack_in) begin
        ram_wr_req_out <= 1'b0;
        ram_wr_addr_out <= ram_wr_addr_out + 9'h001; // R04
      end

      if (bus_start) begin
        state_reg <= S_RX;
        kind_reg <= K_ADDR;
        bit_cnt_reg <= 4'h0;
        ack_ok_reg <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= S_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: sda_oe_out <= 1'b0;
          S_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
              bit_cnt_reg <= 4'h0;
              case (kind_reg)
                K_ADDR: begin
                  if (shift_reg[7:1] == DEV_ADDR) begin
                    rw_reg <= shift_reg[0];
                    kind_reg <= K_SUB;
                    byte_idx_reg <= 2'h0;
                    sda_oe_out <= 1'b1;
                    state_reg <= S_ACK;
                  end else begin
                    state_reg <= S_IDLE;
                  end
                end
                K_SUB: begin
                  sub_reg <= shift_reg;
                  byte_idx_reg <= 2'h0;
                  kind_reg <= K_DATA;
                  sda_oe_out <= 1'b1;
                  state_reg <= S_ACK;
                end
                default: begin
                  // a second word in one transaction is refused
                  if (wr_ok && byte_idx_reg < {1'b0, rd_wide} + 2'h1) begin // R05
                    byte_idx_reg <= byte_idx_reg + 2'h1;
                    sda_oe_out <= 1'b1;
                    state_reg <= S_ACK;
                    if (!rd_wide) begin
                      drive_reg <= shift_reg;
                      port_a_data_drive_out <= shift_reg[2:0]; // R09
                      clock_valid_pad_drive_out <= shift_reg[5:3]; // R10
                      pixel_clock_drive_out <= shift_reg[5:3] | {shift_reg[7:6], 1'b0}; // R11
                    end else if (byte_idx_reg == 2'h0) begin
                      hold_reg <= shift_reg;
                    end else if (sub_reg == `OFS_INDIRECT_READ_ADDRESS) begin
                      ram_rd_addr_out <= rx_word[`RAM_ADDR_MSB:0]; // R02
                      ram_rd_req_out <= 1'b1; // R02
                    end else if (sub_reg == `OFS_INDIRECT_WRITE_ADDRESS) begin
                      ram_wr_addr_out <= rx_word[`RAM_ADDR_MSB:0]; // R03
                    end else begin
                      ram_wr_data_out <= rx_word[`RAM_DATA_MSB:0]; // R04
                      ram_wr_req_out <= 1'b1; // R04
                    end
                  end else begin
                    state_reg <= S_IDLE;
                  end
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                tx_reg <= tx_first;
                sda_oe_out <= ~tx_first[7];
                hold_reg <= rd_val[7:0];
                tx_more_reg <= rd_wide; // R05
                state_reg <= S_TX;
                if (sub_reg == `OFS_INDIRECT_DATA) begin
                  // the buffered word goes out, the next one is fetched
                  ram_rd_addr_out <= ram_rd_addr_out + 9'h001; // R04
                  ram_rd_req_out <= 1'b1; // R04
                end
              end else begin
                sda_oe_out <= 1'b0;
                state_reg <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == `BITS_PER_BYTE) begin
                sda_oe_out <= 1'b0;
                ack_ok_reg <= 1'b0;
                state_reg <= S_TACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe_out <= ~tx_reg[6];
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              // bytes past the word read back as all ones
              if (sda_reg || !tx_more_reg) begin // R05
                state_reg <= S_IDLE;
              end else begin
                ack_ok_reg <= 1'b1;
              end
            end else if (scl_fall && ack_ok_reg) begin
              ack_ok_reg <= 1'b0;
              tx_more_reg <= 1'b0;
              tx_reg <= hold_reg;
              sda_oe_out <= ~hold_reg[7];
              bit_cnt_reg <= 4'h0;
              state_reg <= S_TX;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

endmodule // host_serial_register_port

// ==== src/host_serial_register_port_regs.vh ====
`ifndef HOST_SERIAL_REGISTER_PORT_REGS_VH
`define HOST_SERIAL_REGISTER_PORT_REGS_VH

// serial subaddresses
`define OFS_MAKER_CODE 8'h00
`define OFS_PART_NUMBER_LOW 8'h01
`define OFS_PART_NUMBER_HIGH 8'h02
`define OFS_FIELD_INDICATOR_STATUS 8'h03
`define OFS_INDIRECT_STATUS 8'h35
`define OFS_INDIRECT_READ_ADDRESS 8'h36
`define OFS_INDIRECT_WRITE_ADDRESS 8'h37
`define OFS_INDIRECT_DATA 8'h38
`define OFS_PORT_A_DRIVE_STRENGTH 8'hf8

// indirect status fields
`define STAT_WRITE_PENDING_BIT 0
`define STAT_READ_PENDING_BIT 1
`define STAT_BUSY_BIT 2

// address and data fields of the indirect words
`define RAM_ADDR_MSB 8
`define RAM_DATA_MSB 11

// drive strength fields
`define PORT_A_DATA_DRIVE_LSB 0
`define CLOCK_VALID_PAD_DRIVE_LSB 3
`define PIXEL_CLOCK_EXTRA_DRIVE_LSB 6

// reset values
`define DRIVE_STRENGTH_RESET 8'h00
`define RAM_ADDR_RESET 9'h000
`define RAM_DATA_RESET 12'h000

// default identity and bus address, all values arbitrary
`define DEV_ADDR_DEFAULT 7'h21
`define MAKER_CODE_DEFAULT 8'h5a
`define PART_NUMBER_DEFAULT 16'h1234

// bits per serial byte
`define BITS_PER_BYTE 4'h8

`endif

// ==== tb/host_serial_register_port_chk.sv ====
`timescale 1ns/1ns
module host_serial_register_port_chk (
  input wire mclk_in,
  input wire rst_n_in,
  input wire scl_in,
  input wire sda_oe_out,
  input wire ram_rd_req_out,
  input wire [8:0] ram_rd_addr_out,
  input wire ram_rd_ack_in,
  input wire ram_wr_req_out,
  input wire [8:0] ram_wr_addr_out,
  input wire [11:0] ram_wr_data_out,
  input wire ram_wr_ack_in,
  input wire [2:0] clock_valid_pad_drive_out,
  input wire [2:0] pixel_clock_drive_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence rd_wait;
    ram_rd_req_out && !ram_rd_ack_in;
  endsequence
  sequence wr_wait;
    ram_wr_req_out && !ram_wr_ack_in;
  endsequence
  a_pix_or_cv: assert property ((pixel_clock_drive_out & clock_valid_pad_drive_out)
    == clock_valid_pad_drive_out && pixel_clock_drive_out[0] == clock_valid_pad_drive_out[0])
    else $error("pixel clock drive not built from clock drive");
  a_rd_req_hold: assert property (rd_wait |=> ram_rd_req_out && $stable(ram_rd_addr_out))
    else $error("read request dropped or moved before ack");
  a_wr_req_hold: assert property (wr_wait |=> ram_wr_req_out && $stable(ram_wr_data_out)
    && $stable(ram_wr_addr_out)) else $error("write request dropped or moved before ack");
  a_wr_ptr_step: assert property (ram_wr_req_out && ram_wr_ack_in |=>
    ram_wr_addr_out == $past(ram_wr_addr_out) + 9'h001) else $error("write pointer not stepped");
  a_wr_drop_ack: assert property ($fell(ram_wr_req_out) |-> $past(ram_wr_ack_in))
    else $error("write request dropped without ack");
  a_rd_drop_ack: assert property ($fell(ram_rd_req_out) |-> $past(ram_rd_ack_in))
    else $error("read request dropped without ack");
  a_ack_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("data line pulled while clock high");
  a_oe_steady_hi: assert property (scl_in [*5] |-> $stable(sda_oe_out))
    else $error("data line moved while clock high");
  a_wr_start_low: assert property ($rose(ram_wr_req_out) |-> !scl_in)
    else $error("write request not at a clock low phase");
  a_rd_start_low: assert property ($rose(ram_rd_req_out) |-> !scl_in)
    else $error("read request not at a clock low phase");
endmodule // host_serial_register_port_chk
bind host_serial_register_port host_serial_register_port_chk chk (.mclk_in, .rst_n_in, .scl_in,
  .sda_oe_out, .ram_rd_req_out, .ram_rd_addr_out, .ram_rd_ack_in, .ram_wr_req_out,
  .ram_wr_addr_out, .ram_wr_data_out, .ram_wr_ack_in, .clock_valid_pad_drive_out,
  .pixel_clock_drive_out);

// ==== tb/i2c_host_model.sv ====
`timescale 1ns/1ns
module i2c_host_model (
  input wire mclk_in,
  input wire sda_in,
  output reg scl_out,
  output reg sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task half;
    repeat (10) @(negedge mclk_in);
  endtask
  // also serves as repeated start: data is released while the clock is still low
  task start;
    sda_pull_out = 1'b0;
    half;
    scl_out = 1'b1;
    half;
    sda_pull_out = 1'b1;
    half;
    scl_out = 1'b0;
  endtask
  task stop;
    half;
    sda_pull_out = 1'b1;
    half;
    scl_out = 1'b1;
    half;
    sda_pull_out = 1'b0;
    half;
  endtask
  // data changes three clocks into the low phase, never near a clock edge
  task xbits(input [8:0] d, output [8:0] q);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      repeat (3) @(negedge mclk_in);
      sda_pull_out = !d[i];
      repeat (7) @(negedge mclk_in);
      scl_out = 1'b1;
      half;
      q[i] = sda_in;
      scl_out = 1'b0;
    end
  endtask
endmodule // i2c_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  reg mclk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg field_in = 1'b0;
  reg ram_rd_ack_in = 1'b0;
  reg [11:0] ram_rd_data_in = 12'h000;
  reg ram_wr_ack_in = 1'b0;
  wire scl, sda_pull, sda_out, sda_oe_out, ram_rd_req_out, ram_wr_req_out;
  wire [8:0] ram_rd_addr_out, ram_wr_addr_out;
  wire [11:0] ram_wr_data_out;
  wire [2:0] pa_drv, cv_drv, px_drv;
  wire sda = !(sda_pull | (sda_oe_out & !sda_out));
  reg [11:0] mem [0:511];
  integer bad_count = 0, compares = 0, cyc = 0, wait_rd = 0, wait_wr = 0;
  localparam [7:0] MAKER = 8'h3c; // arbitrary
  localparam [15:0] PART = 16'hbe71; // arbitrary
  always #25 mclk_in = ~mclk_in;
  host_serial_register_port #(.DEV_ADDR(7'h21), .MAKER_CODE(MAKER), .PART_NUMBER(PART)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .field_in(field_in), .ram_rd_req_out(ram_rd_req_out),
    .ram_rd_addr_out(ram_rd_addr_out), .ram_rd_ack_in(ram_rd_ack_in),
    .ram_rd_data_in(ram_rd_data_in), .ram_wr_req_out(ram_wr_req_out),
    .ram_wr_addr_out(ram_wr_addr_out), .ram_wr_data_out(ram_wr_data_out),
    .ram_wr_ack_in(ram_wr_ack_in), .port_a_data_drive_out(pa_drv),
    .clock_valid_pad_drive_out(cv_drv), .pixel_clock_drive_out(px_drv));
  i2c_host_model host (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(sda_pull));
  // slow ram: requests stay pending across a whole status read
  always @(negedge mclk_in) begin
    cyc = cyc + 1;
    ram_rd_ack_in <= 1'b0;
    ram_wr_ack_in <= 1'b0;
    ram_rd_data_in <= ~ram_rd_data_in;
    wait_rd = (ram_rd_req_out && !ram_rd_ack_in) ? wait_rd + 1 : 0;
    wait_wr = (ram_wr_req_out && !ram_wr_ack_in) ? wait_wr + 1 : 0;
    if (wait_rd == 1500) begin
      ram_rd_ack_in <= 1'b1;
      ram_rd_data_in <= mem[ram_rd_addr_out];
    end
    if (wait_wr == 1500) begin
      ram_wr_ack_in <= 1'b1;
      mem[ram_wr_addr_out] = ram_wr_data_out;
    end
    if (cyc > 90000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wreg(input [7:0] sub, input [23:0] d, input integer n, output ok);
    reg [8:0] q;
    integer i;
    host.start;
    host.xbits({8'h42, 1'b1}, q);
    host.xbits({sub, 1'b1}, q);
    for (i = n - 1; i >= 0; i = i - 1) host.xbits({d[i*8 +: 8], 1'b1}, q);
    ok = !q[0];
    host.stop;
  endtask
  task rreg(input [7:0] sub, input integer n, output [15:0] v);
    reg [8:0] q;
    integer i;
    host.start;
    host.xbits({8'h42, 1'b1}, q);
    host.xbits({sub, 1'b1}, q);
    host.start;
    host.xbits({8'h43, 1'b1}, q);
    v = 16'h0000;
    for (i = n; i > 0; i = i - 1) begin
      host.xbits({8'hff, i == 1}, q);
      v = {v[7:0], q[8:1]};
    end
    host.stop;
  endtask
  task wait_idle;
    reg [15:0] v;
    integer k;
    v = 16'h0004;
    for (k = 0; k < 20 && v[2] !== 1'b0; k = k + 1) rreg(8'h35, 1, v);
    check(v & 16'h0004, 16'h0000);
  endtask
  task t_ident;
    reg [15:0] v;
    rreg(8'h00, 1, v);
    check(v, {8'h00, MAKER});
    rreg(8'h01, 1, v);
    check(v, {8'h00, PART[7:0]});
    rreg(8'h02, 1, v);
    check(v, {8'h00, PART[15:8]});
    field_in = 1'b1;
    rreg(8'h03, 1, v);
    check(v & 16'h0001, 16'h0001);
    field_in = 1'b0;
    rreg(8'h03, 1, v);
    check(v & 16'h0001, 16'h0000);
    $display("ident test done");
  endtask
  task t_drive;
    reg [15:0] v;
    reg ok;
    wreg(8'hf8, 24'h0000d5, 1, ok);
    check(pa_drv, 16'h0005);
    check(cv_drv, 16'h0002);
    check(px_drv, 16'h0006);
    rreg(8'hf8, 1, v);
    check(v, 16'h00d5);
    wreg(8'h00, 24'h000077, 1, ok);
    check(ok, 16'h0000);
    rreg(8'h00, 1, v);
    check(v, {8'h00, MAKER});
    $display("drive test done");
  endtask
  task t_ram_wr;
    reg [15:0] v;
    reg ok;
    wreg(8'h37, 24'h0001ff, 2, ok);
    wait_idle;
    check(ram_wr_addr_out, 16'h01ff);
    wreg(8'h38, 24'h000abc, 2, ok);
    rreg(8'h35, 1, v);
    check(v, 16'h0005);
    wait_idle;
    wreg(8'h38, 24'h000123, 2, ok);
    wait_idle;
    check(mem[9'h1ff], 16'h0abc);
    check(mem[9'h000], 16'h0123);
    check(ram_wr_addr_out, 16'h0001);
    wreg(8'h38, 24'h045678, 3, ok);
    check(ok, 16'h0000);
    wait_idle;
    check(mem[9'h001], 16'h0456);
    $display("ram write test done");
  endtask
  task t_ram_rd;
    reg [15:0] v;
    reg ok;
    wreg(8'h36, 24'h0001ff, 2, ok);
    rreg(8'h35, 1, v);
    check(v, 16'h0006);
    wait_idle;
    rreg(8'h38, 2, v);
    check(v, 16'h0abc);
    wait_idle;
    rreg(8'h38, 2, v);
    check(v, 16'h0123);
    wait_idle;
    check(ram_rd_addr_out, 16'h0001);
    $display("ram read test done");
  endtask
  initial begin
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    t_ident;
    t_drive;
    t_ram_wr;
    t_ram_rd;
    end_sim;
  end
endmodule // tb_top
